// File: design/cpv_params.svh
`ifndef CPV_PARAMS_SVH
`define CPV_PARAMS_SVH

// register offsets
`define CPV_CTRL_OFS 8'h00
`define CPV_PROC_OFS 8'h04
`define CPV_STAT_OFS 8'h08

// control field positions
`define CPV_CTRL_WW 0
`define CPV_CTRL_GAIN 1
`define CPV_CTRL_REQ 2
`define CPV_CTRL_STROBE 3
`define CPV_CTRL_NARROW 4

// reset values
`define CPV_CTRL_RST 5'h02
`define CPV_BLACK_RST 12'h000
`define CPV_GAIN_ADD_RST 8'h00

// switch positions 1..5 on bits 0..4
`define CPV_DIP_WW 0
`define CPV_DIP_METHOD 2
`define CPV_DIP_GAIN 3

// broadcast raster, in pixel clocks and lines
`define CPV_H_ACTIVE 640
`define CPV_H_TOTAL 780
`define CPV_V_ACTIVE 480
`define CPV_V_TOTAL 525

// merge knee of the bin merging curve
`define CPV_MERGE_KNEE 12'h200

`endif

// File: design/cpv_pkg.sv
package cpv_pkg;

  typedef enum logic [1:0] {VAR_MONO, VAR_COLOUR, VAR_STEREO} variant_type;

  typedef logic [11:0] pix_type;

  typedef struct packed {
    logic req_mode;
    logic strobe_mode;
    logic narrow;
    logic stretch;
    logic gain_en;
    logic ww_en;
    logic [11:0] black;
    logic [7:0] gain_add;
  } cfg_type;

endpackage : cpv_pkg

// File: design/video_link_if.sv
`timescale 1ns/1ps
interface video_link_if;
  logic hblank;
  logic vblank;
  logic frame_start;

  modport gen (output hblank, output vblank, output frame_start);
  modport sink (input hblank, input vblank, input frame_start);
endinterface : video_link_if

// File: design/sync_bits.sv
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // =====================================
  // two flops per bit
  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_q[b] <= 1'h0;
          sync_q[b] <= 1'h0;
        end
        else
        begin
          meta_q[b] <= d_i[b];
          sync_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate

  assign q_o = sync_q;
endmodule : sync_bits

// File: design/video_timing_gen.sv
`timescale 1ns/1ps
module video_timing_gen #(
  parameter int H_ACTIVE = 640,
  parameter int H_TOTAL = 780,
  parameter int V_ACTIVE = 480,
  parameter int V_TOTAL = 525
) (
  input wire logic clk_i,
  input wire logic rst_i,
  video_link_if.gen vl
);
  logic [11:0] h_q;
  logic [11:0] v_q;
  logic h_last;
  logic v_last;

  assign h_last = (h_q == 12'(H_TOTAL - 1));
  assign v_last = (v_q == 12'(V_TOTAL - 1));

  // =====================================
  // raster counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      h_q <= 12'(H_TOTAL - 1);
      v_q <= 12'(V_TOTAL - 1);
    end
    else if (h_last)
    begin
      h_q <= 12'h000;
      v_q <= v_last ? 12'h000 : 12'(v_q + 12'h001);
    end
    else
    begin
      h_q <= 12'(h_q + 12'h001);
    end
  end

  assign vl.hblank = (h_q >= 12'(H_ACTIVE));
  assign vl.vblank = (v_q >= 12'(V_ACTIVE));
  assign vl.frame_start = h_last & v_last;
endmodule : video_timing_gen

// File: design/camera_parallel_video_port.sv
`timescale 1ns/1ps
`include "cpv_params.svh"
module camera_parallel_video_port
  import cpv_pkg::*;
#(
  parameter variant_type VARIANT = VAR_MONO,
  parameter int H_ACTIVE = `CPV_H_ACTIVE,
  parameter int H_TOTAL = `CPV_H_TOTAL,
  parameter int V_ACTIVE = `CPV_V_ACTIVE,
  parameter int V_TOTAL = `CPV_V_TOTAL
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic pix_clk_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic reset_run_n_i,
  input wire logic frame_request_input_i,
  input wire logic [4:0] dip_sw_i,
  input wire logic [11:0] pix_a_i,
  input wire logic [11:0] pix_b_i,
  output logic pix_clk_o,
  output logic [11:0] data_a_o,
  output logic [11:0] data_b_o,
  output logic hblank_o,
  output logic vblank_o,
  output logic out_oe_o,
  output logic strobe_o,
  output logic [11:0] host_pix_o,
  output logic [7:0] host_status_o
);
  // =====================================
  // system domain synchronisers
  logic run_s;
  logic ww_sw_s;
  logic method_sw_s;
  logic gain_sw_s;
  logic ack_s;
  logic frame_tgl_s;
  logic dev_rst_q;
  logic seen_q;
  logic frame_tgl_q;

  sync_bits #(.W(6)) u_sys_sync (
    .clk_i(sys_clk_i),
    .rst_i(srst_i),
    .d_i({reset_run_n_i, dip_sw_i[`CPV_DIP_WW], dip_sw_i[`CPV_DIP_METHOD],
          dip_sw_i[`CPV_DIP_GAIN], seen_q, frame_tgl_q}),
    .q_o({run_s, ww_sw_s, method_sw_s, gain_sw_s, ack_s, frame_tgl_s})
  );

  // device reset while pin low
  always_ff @(posedge sys_clk_i)
  begin
    dev_rst_q <= srst_i | ~run_s;
  end

  // =====================================
  // switch capture after reset release
  logic strap_done_q;
  logic ww_sw_q;
  logic method_sw_q;
  logic gain_sw_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (dev_rst_q)
    begin
      strap_done_q <= 1'h0;
      ww_sw_q <= 1'h0;
      method_sw_q <= 1'h0;
      gain_sw_q <= 1'h0;
    end
    else if (!strap_done_q)
    begin
      // positions 2 and 5 never sampled
      strap_done_q <= 1'h1;
      ww_sw_q <= ww_sw_s;
      method_sw_q <= method_sw_s;
      gain_sw_q <= gain_sw_s;
    end
  end

  // =====================================
  // apb register file
  logic [4:0] ctrl_q;
  logic [11:0] black_q;
  logic [7:0] gain_add_q;
  logic [7:0] frame_cnt_q;
  logic frame_prev_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic err_d;
  logic ww_eff;
  logic gain_eff;
  logic stretch_eff;

  assign ww_eff = ww_sw_q | ctrl_q[`CPV_CTRL_WW];
  assign gain_eff = gain_sw_q & ctrl_q[`CPV_CTRL_GAIN];
  assign stretch_eff = (VARIANT == VAR_COLOUR) ? 1'h1 : method_sw_q;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    err_d = 1'h0;
    case (paddr_i)
      `CPV_CTRL_OFS: rd_d = {27'h000_0000, ctrl_q};
      `CPV_PROC_OFS: rd_d = {8'h00, gain_add_q, 4'h0, black_q};
      `CPV_STAT_OFS: rd_d = {16'h0000, frame_cnt_q, 3'h0, strap_done_q, 1'h0,
                             stretch_eff, gain_eff, ww_eff};
      default: err_d = 1'h1;
    endcase
  end

  // answer prepared in setup phase
  always_ff @(posedge sys_clk_i)
  begin
    if (dev_rst_q)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'h0;
    end
    else if (psel_i && !penable_i)
    begin
      prdata_q <= pwrite_i ? 32'h0000_0000 : rd_d;
      pslverr_q <= err_d;
    end
  end

  assign pready_o = 1'h1;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q & psel_i & penable_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (dev_rst_q)
    begin
      ctrl_q <= `CPV_CTRL_RST;
      black_q <= `CPV_BLACK_RST;
      gain_add_q <= `CPV_GAIN_ADD_RST;
    end
    else if (psel_i && penable_i && pwrite_i)
    begin
      if (paddr_i == `CPV_CTRL_OFS)
      begin
        ctrl_q <= pwdata_i[4:0];
      end
      if (paddr_i == `CPV_PROC_OFS)
      begin
        black_q <= pwdata_i[11:0];
        gain_add_q <= pwdata_i[23:16];
      end
    end
  end

  // frames counted on toggles from link side
  always_ff @(posedge sys_clk_i)
  begin
    if (dev_rst_q)
    begin
      frame_cnt_q <= 8'h00;
      frame_prev_q <= 1'h0;
    end
    else
    begin
      frame_prev_q <= frame_tgl_s;
      if (frame_tgl_s != frame_prev_q)
      begin
        frame_cnt_q <= 8'(frame_cnt_q + 8'h01);
      end
    end
  end

  // =====================================
  // configuration crossing, toggle handshake
  cfg_type cfg_d;
  cfg_type cfg_hold_q;
  logic req_tgl_q;

  always_comb
  begin
    cfg_d.req_mode = ctrl_q[`CPV_CTRL_REQ];
    cfg_d.strobe_mode = ctrl_q[`CPV_CTRL_STROBE];
    cfg_d.narrow = ctrl_q[`CPV_CTRL_NARROW];
    cfg_d.stretch = stretch_eff;
    cfg_d.gain_en = gain_eff;
    cfg_d.ww_en = ww_eff;
    cfg_d.black = black_q;
    cfg_d.gain_add = gain_add_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (dev_rst_q)
    begin
      cfg_hold_q <= '0;
      req_tgl_q <= 1'h0;
    end
    else if ((req_tgl_q == ack_s) && (cfg_d != cfg_hold_q))
    begin
      cfg_hold_q <= cfg_d;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // =====================================
  // link domain
  logic rst_l;
  logic req_pin_s;
  logic req_tgl_s;
  cfg_type cfg_l_q;

  sync_bits #(.W(3)) u_link_sync (
    .clk_i(pix_clk_i),
    .rst_i(1'h0),
    .d_i({dev_rst_q, frame_request_input_i, req_tgl_q}),
    .q_o({rst_l, req_pin_s, req_tgl_s})
  );

  video_link_if vl ();

  video_timing_gen #(
    .H_ACTIVE(H_ACTIVE),
    .H_TOTAL(H_TOTAL),
    .V_ACTIVE(V_ACTIVE),
    .V_TOTAL(V_TOTAL)
  ) u_timing (
    .clk_i(pix_clk_i),
    .rst_i(rst_l),
    .vl(vl)
  );

  // one settings set feeds every output
  always_ff @(posedge pix_clk_i)
  begin
    if (rst_l)
    begin
      cfg_l_q <= '0;
      seen_q <= 1'h0;
    end
    else if (req_tgl_s != seen_q)
    begin
      cfg_l_q <= cfg_hold_q;
      seen_q <= req_tgl_s;
    end
  end

  // =====================================
  // frame request
  logic req_prev_q;
  logic pend_q;
  logic frame_en_q;
  logic req_rise;

  assign req_rise = req_pin_s & ~req_prev_q;

  always_ff @(posedge pix_clk_i)
  begin
    if (rst_l)
    begin
      req_prev_q <= 1'h0;
      pend_q <= 1'h0;
      frame_en_q <= 1'h1;
      frame_tgl_q <= 1'h0;
    end
    else
    begin
      req_prev_q <= req_pin_s;
      if (!cfg_l_q.req_mode || vl.frame_start)
      begin
        pend_q <= 1'h0;
      end
      else if (req_rise)
      begin
        pend_q <= 1'h1;
      end
      if (vl.frame_start)
      begin
        frame_en_q <= !cfg_l_q.req_mode | pend_q | req_rise;
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end

  // =====================================
  // pixel processing, one lane per bus
  pix_type s1_q [2];
  pix_type out_v [2];
  logic s1_hb_q;
  logic s1_vb_q;
  logic s1_oe_q;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_lane
      pix_type in_v;
      pix_type blk;
      pix_type val;
      pix_type knee;
      logic [12:0] sum;
      logic [7:0] red;
      assign in_v = (ch == 0) ? pix_a_i : pix_b_i;
      assign knee = 12'(s1_q[ch] - `CPV_MERGE_KNEE);

      always_comb
      begin
        blk = cfg_l_q.stretch ? ((in_v < cfg_l_q.black) ? 12'h000 :
                                  12'(in_v - cfg_l_q.black)) : in_v;
        sum = {1'h0, blk} + {1'h0, cfg_l_q.gain_add, 4'h0};
        val = cfg_l_q.gain_en ? (sum[12] ? 12'hfff : sum[11:0]) : blk;
        if (VARIANT == VAR_COLOUR && ch == 1)
        begin
          val = {4'h0, in_v[7:0]};
        end
      end

      always_comb
      begin
        if (cfg_l_q.stretch)
        begin
          red = s1_q[ch][11:4];
        end
        else if (s1_q[ch] < `CPV_MERGE_KNEE)
        begin
          red = {1'h0, s1_q[ch][8:2]};
        end
        else
        begin
          red = {1'h1, knee[11:5]};
        end
      end

      // width per variant
      always_comb
      begin
        if (VARIANT == VAR_MONO && ch == 1)
        begin
          out_v[ch] = 12'h000;
        end
        else if (VARIANT == VAR_COLOUR)
        begin
          out_v[ch] = (ch == 0) ? {4'h0, red} : s1_q[ch];
        end
        else
        begin
          out_v[ch] = cfg_l_q.narrow ? {4'h0, red} : s1_q[ch];
        end
      end

      always_ff @(posedge pix_clk_i)
      begin
        if (rst_l)
        begin
          s1_q[ch] <= 12'h000;
        end
        else
        begin
          s1_q[ch] <= val;
        end
      end
    end
  endgenerate

  // =====================================
  // output flops on the pixel clock
  always_ff @(posedge pix_clk_i)
  begin
    if (rst_l)
    begin
      s1_hb_q <= 1'h1;
      s1_vb_q <= 1'h1;
      s1_oe_q <= 1'h0;
      data_a_o <= 12'h000;
      data_b_o <= 12'h000;
      hblank_o <= 1'h1;
      vblank_o <= 1'h1;
      out_oe_o <= 1'h0;
      strobe_o <= 1'h0;
      host_pix_o <= 12'h000;
      host_status_o <= 8'h00;
    end
    else
    begin
      s1_hb_q <= vl.hblank;
      s1_vb_q <= vl.vblank;
      s1_oe_q <= frame_en_q;
      out_oe_o <= s1_oe_q;
      data_a_o <= s1_oe_q ? out_v[0] : 12'h000;
      data_b_o <= s1_oe_q ? out_v[1] : 12'h000;
      hblank_o <= s1_oe_q ? s1_hb_q : 1'h1;
      vblank_o <= s1_oe_q ? s1_vb_q : 1'h1;
      strobe_o <= !cfg_l_q.req_mode & cfg_l_q.strobe_mode & vl.vblank;
      host_pix_o <= s1_q[0];
      host_status_o <= {2'h0, pend_q, frame_en_q, cfg_l_q.req_mode,
                        cfg_l_q.stretch, cfg_l_q.gain_en, cfg_l_q.ww_en};
    end
  end

  // receiver samples on the rising edge of this clock
  assign pix_clk_o = pix_clk_i;

  // =====================================
  // checks
  sequence s_frame_req;
    vl.frame_start && cfg_l_q.req_mode && (pend_q || req_rise);
  endsequence

  sequence s_frame_noreq;
    vl.frame_start && cfg_l_q.req_mode && !pend_q && !req_rise;
  endsequence

  chk_ww_forced: assert property (@(posedge sys_clk_i) disable iff (dev_rst_q)
    strap_done_q && ww_sw_q |-> ww_eff && stretch_eff == (VARIANT == VAR_COLOUR
    ? 1'h1 : method_sw_q))
    else $error("weighted window not forced on");

  chk_gain_locked: assert property (@(posedge sys_clk_i) disable iff (dev_rst_q)
    strap_done_q && !gain_sw_q |-> !gain_eff)
    else $error("gain mapping enabled while switch off");

  chk_method_sel: assert property (@(posedge sys_clk_i) disable iff (dev_rst_q)
    strap_done_q && VARIANT != VAR_COLOUR |-> stretch_eff == method_sw_q)
    else $error("reduction method differs from switch");

  chk_strobe_low: assert property (@(posedge pix_clk_i) disable iff (rst_l)
    !cfg_l_q.req_mode && cfg_l_q.strobe_mode && !vl.vblank |=> !strobe_o)
    else $error("strobe high while rows integrate");

  chk_vblank_align: assert property (@(posedge pix_clk_i) disable iff (rst_l)
    out_oe_o |-> vblank_o == $past(vl.vblank, 2))
    else $error("frame blanking misaligned");

  chk_hblank_align: assert property (@(posedge pix_clk_i) disable iff (rst_l)
    out_oe_o |-> hblank_o == $past(vl.hblank, 2))
    else $error("line blanking misaligned");

  chk_req_taken: assert property (@(posedge pix_clk_i) disable iff (rst_l)
    s_frame_req |-> ##3 out_oe_o ##1 (out_oe_o && !vblank_o))
    else $error("requested frame not driven");

  chk_one_frame: assert property (@(posedge pix_clk_i) disable iff (rst_l)
    s_frame_noreq |-> ##3 !out_oe_o [*2])
    else $error("frame driven without request");

  chk_free_run: assert property (@(posedge pix_clk_i) disable iff (rst_l)
    vl.frame_start && !cfg_l_q.req_mode |-> ##3 out_oe_o)
    else $error("free running frame not driven");

endmodule : camera_parallel_video_port

// File: tb/video_capture_model.sv
`timescale 1ns/1ps
// ==========
// capture logic at the far side of the pixel bus
module video_capture_model (
  input wire logic pix_clk_i,
  input wire logic hblank_i,
  input wire logic vblank_i,
  input wire logic oe_i,
  input wire logic strobe_i,
  input wire logic [11:0] data_b_i,
  output int frames_o = 0,
  output int last_px_o = 0,
  output int bad_o = 0,
  output int strobes_o = 0
);
  int px_q = 0;
  logic vb_q = 1'b1;
  logic st_q = 1'b0;

  // everything latched on the rising pixel clock edge
  always @(posedge pix_clk_i)
  begin
    vb_q <= vblank_i;
    st_q <= strobe_i;
    if (strobe_i)
      strobes_o <= strobes_o + 1;
    if (vb_q && !vblank_i && oe_i)
      frames_o <= frames_o + 1;
    if (!vblank_i && !hblank_i)
      px_q <= px_q + 1;
    if (!vb_q && vblank_i)
    begin
      last_px_o <= px_q;
      px_q <= 0;
    end
    // strobe leads the frame blanking output by one pixel clock
    if ((st_q && !vblank_i) || (data_b_i !== 12'h000))
      bad_o <= bad_o + 1;
  end
endmodule : video_capture_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "cpv_params.svh"
// ==========
// bench top
module tb_top
  import cpv_pkg::*;
;
  localparam int FR = 12 * 6 * 8;
  logic sys_clk, pix_clk, srst, psel, penable, pwrite, run_n, freq;
  logic [7:0] paddr, rnd, hstat;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] dip;
  logic [11:0] pa, pb, da, db, hpix, pa_d1, pa_d2, ex;
  logic pready, pslverr, pclk_o, hb, vb, oe, strobe, er;
  int n_errors, checked, cyc, frames, last_px, bad, f0, b0, strobes, s0;

  camera_parallel_video_port #(.VARIANT(VAR_MONO), .H_ACTIVE(8), .H_TOTAL(12),
    .V_ACTIVE(4), .V_TOTAL(6)) camera_parallel_video_port_i (
    .sys_clk_i(sys_clk), .srst_i(srst), .pix_clk_i(pix_clk), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .reset_run_n_i(run_n),
    .frame_request_input_i(freq), .dip_sw_i(dip), .pix_a_i(pa), .pix_b_i(pb),
    .pix_clk_o(pclk_o), .data_a_o(da), .data_b_o(db), .hblank_o(hb), .vblank_o(vb),
    .out_oe_o(oe), .strobe_o(strobe), .host_pix_o(hpix), .host_status_o(hstat));

  video_capture_model video_capture_model_i (.pix_clk_i(pclk_o), .hblank_i(hb),
    .vblank_i(vb), .oe_i(oe), .strobe_i(strobe), .data_b_i(db), .frames_o(frames),
    .last_px_o(last_px), .bad_o(bad), .strobes_o(strobes));

  // ==========
  // clocks, random pixels, timeout
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    pix_clk = 1'b0;
    #13;
    forever #32 pix_clk = ~pix_clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  always @(posedge pix_clk)
  begin
    rnd <= lfsr_next(rnd);
    pa <= {rnd, rnd[3:0]};
    pb <= {rnd[3:0], rnd};
    pa_d1 <= pa;
    pa_d2 <= pa_d1;
  end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      close_out();
    end
  end

  // ==========
  // reference model and helpers
  function automatic logic [31:0] exp_stat(input logic [4:0] s, input logic [4:0] c);
    return {27'h000_0000, 1'b1, 1'b0, s[2], s[3] & c[1], s[0] | c[0]};
  endfunction : exp_stat

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ==========
  // main sequence
  initial
  begin
    n_errors = 0;
    checked = 0;
    cyc = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    run_n = 1'b0;
    freq = 1'b0;
    dip = 5'h00;
    pa = 12'h000;
    pb = 12'h000;
    rnd = 8'h26;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      dip <= (i == 0) ? 5'h00 : (i == 1) ? 5'h0d : rnd[4:0];
      run_n <= 1'b0;
      repeat (30) @(posedge sys_clk);
      run_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      apb(1'b0, `CPV_CTRL_OFS, 32'h0000_0000, rd, er);
      chk("ctrl reset", {27'h000_0000, `CPV_CTRL_RST}, rd);
      apb(1'b0, `CPV_STAT_OFS, 32'h0000_0000, rd, er);
      chk("stat reset", exp_stat(dip, 5'h02), rd & 32'h0000_0017);
      apb(1'b1, `CPV_CTRL_OFS, 32'h0000_0000, rd, er);
      apb(1'b0, `CPV_STAT_OFS, 32'h0000_0000, rd, er);
      chk("stat cleared", exp_stat(dip, 5'h00), rd & 32'h0000_0017);
      apb(1'b1, `CPV_CTRL_OFS, 32'h0000_0003, rd, er);
      apb(1'b0, `CPV_STAT_OFS, 32'h0000_0000, rd, er);
      chk("stat set", exp_stat(dip, 5'h03), rd & 32'h0000_0017);
      $display("switch pass %0d done", i);
    end
    b0 = bad;
    apb(1'b0, 8'h0c, 32'h0000_0000, rd, er);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, er});
    chk("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, `CPV_PROC_OFS, 32'h00ab_0123, rd, er);
    apb(1'b0, `CPV_PROC_OFS, 32'h0000_0000, rd, er);
    chk("proc readback", 32'h00ab_0123, rd);
    $display("register test done");
    f0 = frames;
    repeat (3 * FR) @(posedge sys_clk);
    chk("free frames", 32'h0000_0001, {31'h0000_0000, (frames - f0) >= 2});
    chk("active pixels", 32'd32, last_px);
    chk("host status", {28'h000_0000, 1'b0, dip[2], dip[3], 1'b1}, {24'h00_0000, hstat} & 32'h0000_000f);
    $display("raster test done");
    apb(1'b1, `CPV_CTRL_OFS, 32'h0000_0004, rd, er);
    repeat (2 * FR) @(posedge sys_clk);
    f0 = frames;
    repeat (2 * FR) @(posedge sys_clk);
    chk("idle frames", 32'd0, frames - f0);
    @(posedge pix_clk);
    freq <= 1'b1;
    repeat (8) @(posedge pix_clk);
    freq <= 1'b0;
    repeat (3 * FR) @(posedge sys_clk);
    chk("requested frames", 32'd1, frames - f0);
    $display("request test done");
    apb(1'b1, `CPV_CTRL_OFS, 32'h0000_0008, rd, er);
    s0 = strobes;
    repeat (2 * FR) @(posedge sys_clk);
    chk("strobe and lane b", 32'd0, bad - b0);
    chk("strobe seen", 32'h0000_0001, {31'h0000_0000, strobes > s0});
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pix_clk);
      ex = (dip[2] && pa_d2 < 12'h123) ? 12'h000 : dip[2] ? 12'(pa_d2 - 12'h123) : pa_d2;
      chk("host pixel", {20'h0_0000, ex}, {20'h0_0000, hpix});
      chk("pixel data a", {20'h0_0000, ex}, {20'h0_0000, da});
    end
    $display("strobe test done");
    close_out();
  end
endmodule : tb_top
